// *** apbf_map.svh ***
// Purpose: offsets, field positions, reset values and sizes of the async packet buffer formatter
// Assumes: 16-bit register port with a 3-bit word address
// Notes:   definitions only
`ifndef APBF_MAP_SVH
`define APBF_MAP_SVH

// register word addresses
`define APBF_REG_NODE_ID   3'h0
`define APBF_REG_TX_DATA   3'h1
`define APBF_REG_TX_CTRL   3'h2
`define APBF_REG_RX_DATA   3'h3
`define APBF_REG_STATUS    3'h4

// reset values
`define APBF_NODE_ID_RST   16'hFFC0
`define APBF_ZERO16        16'h0000

// field constants
`define APBF_LOCAL_BUS     10'h3FF
`define APBF_PRIO_ZERO     4'h0
`define APBF_LOCK_ZERO     16'h0000
`define APBF_TC_STREAM     4'hA
`define APBF_TC_LOCK_REQ   4'h9
`define APBF_TC_LOCK_RSP   4'hB

// bit positions
`define APBF_BUSSEL_BIT    23
`define APBF_CTRL_NEWPKT   0
`define APBF_TRL_SPD_LSB   16
`define APBF_TRL_ACK_LSB   0

// receive buffer sizing
`define APBF_DEPTH         7'h40
`define APBF_HDR_FULL      2'h3
`define APBF_ROOM_HDR      7'h05
`define APBF_ROOM_DATA     7'h02

`endif

// *** apbf_pkg.sv ***
// Purpose: types shared by the async packet buffer formatter
// Assumes: nothing beyond standard SystemVerilog
// Notes:   constants live in apbf_map.svh
package apbf_pkg;

    // receive record layouts
    typedef enum logic [1:0] {
        APBF_KIND_QUAD,
        APBF_KIND_BLOCK,
        APBF_KIND_STREAM
    } apbf_kind_t;

    // header fields parsed by the link logic
    typedef struct packed {
        apbf_kind_t  kind;
        logic [3:0]  transactionCode;
        logic [5:0]  transactionTag;
        logic [1:0]  retryCode;
        logic [15:0] targetNodeIdentifier;
        logic [15:0] senderNodeIdentifier;
        logic [47:0] targetOffsetAddress;
        logic [15:0] payloadLength;
        logic [15:0] lockSubcode;
        logic [31:0] quadletData;
        logic [5:0]  channel;
        logic [3:0]  app;
    } apbf_rx_hdr_t;

    // end-of-packet status
    typedef struct packed {
        logic [2:0] speedCode;
        logic [3:0] returnedAckCode;
    } apbf_rx_trl_t;

    // one quadlet toward the link
    typedef struct packed {
        logic [31:0] quad;
        logic [7:0]  index;
        logic [15:0] senderNodeIdentifier;
    } apbf_tx_quad_t;

endpackage : apbf_pkg

// *** apbf_word_joiner.sv ***
// Purpose: joins two 16-bit host writes into one quadlet, upper half first
// Assumes: writes come from logic on clk
// Notes:   clear drops a pending upper half
`timescale 1ns/1ps
module apbf_word_joiner (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        clear,
    input  wire logic        halfValid,
    input  wire logic [15:0] half,
    output logic             quadValid,
    output logic [31:0]      quad,
    output logic             upperPending
);
    logic        phase_q;
    logic [15:0] upper_q;

    // phase tracks which half comes next
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                phase_q <= 1'b0;
            end else if (halfValid) begin
                phase_q <= ~phase_q; // R16
            end
        end
    end

    // upper half held until the lower half arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upper_q <= 16'h0000;
        end else if (ce && halfValid && !phase_q && !clear) begin
            upper_q <= half;
        end
    end

    // quadlet out on the lower half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quadValid <= 1'b0;
            quad      <= 32'h0000_0000;
        end else if (ce) begin
            quadValid <= halfValid && phase_q && !clear;
            if (halfValid && phase_q && !clear) begin
                quad <= {upper_q, half}; // R16
            end
        end
    end

    assign upperPending = phase_q;

endmodule : apbf_word_joiner

// *** apbf_async_packet_buffer_format.sv ***
// Purpose: builds receive buffer records and feeds transmit quadlets for the async packet buffers
// Assumes: link-side ports driven by logic on clk; host port is 16 bits wide
// Notes:   host reads/writes each quadlet as two halves, upper first
//
// Notes on behaviour
// R1: bus select 1 gives local bus 3FF
// R2: host keeps tags 0..F, response tag matches
// R3: host writes priority as 0000b
// R4: receive record priority stored as 0000b
// R5: node identifier is 10-bit bus, 6-bit node
// R6: sender identifier stored in receive record
// R7: host bounds payload length by speed
// R8: host writes lock subcode zero unless lock
// R9: stored lock subcode zero unless lock code
// R10: host pads last payload quadlet with zeros
// R11: received speed and ack code recorded
// R12: 48-bit target offset stored for requests
// R13: host uses code A for streams
// R14: stream record stores code A and fields
// R15: host supplies stream header fields
// R16: quadlets pass as two halves, upper first
// R17: host puts response code in second quadlet
// R18: received transaction code stored in record
// R19: retry code set on transmit, stored on receive
// R20: host writes headers before payload, in order
`timescale 1ns/1ps
`include "apbf_map.svh"
module apbf_async_packet_buffer_format
    import apbf_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [2:0]    regAddr,
    input  wire logic [15:0]   regWdata,
    input  wire logic          regWrite,
    input  wire logic          regRead,
    output logic [15:0]        regRdata,
    input  wire logic          rxHdrValid,
    input  wire apbf_rx_hdr_t  rxHdr,
    output logic               rxHdrReady,
    input  wire logic          rxDataValid,
    input  wire logic [31:0]   rxData,
    output logic               rxDataReady,
    input  wire logic          rxEndValid,
    input  wire apbf_rx_trl_t  rxTrailer,
    output logic               rxEndReady,
    output logic               txValid,
    output apbf_tx_quad_t      txOut
);
    typedef enum logic [1:0] {
        APBF_RX_IDLE,
        APBF_RX_HDR,
        APBF_RX_DATA
    } apbf_rx_state_t;

    apbf_rx_state_t rxState_q;
    apbf_rx_hdr_t   hdr_q;
    logic [1:0]     hdrIdx_q;
    logic [31:0]    recMem [0:63];
    logic [5:0]     wrPtr_q;
    logic [5:0]     rdPtr_q;
    logic [6:0]     count_q;
    logic [6:0]     room;
    logic [15:0]    nodeId_q;
    logic [15:0]    lowHold_q;
    logic           rxPhase_q;
    logic           memWe;
    logic [31:0]    memWdata;
    logic [31:0]    headQuad;
    logic           pop;
    logic           txHalf;
    logic           txClear;
    logic           txClear_q;
    logic           joinValid;
    logic [31:0]    joinQuad;
    logic           txUpperPending;
    logic           hdrTake;
    logic           endTake;
    logic           dataTake;

    // true for the two lock transaction codes
    function automatic logic isLock(input logic [3:0] code);
        isLock = (code == `APBF_TC_LOCK_REQ) || (code == `APBF_TC_LOCK_RSP);
    endfunction : isLock

    // header quadlet idx of a receive record
    function automatic logic [31:0] hdrQuad(input apbf_rx_hdr_t h, input logic [1:0] idx);
        logic [15:0] sub;
        sub = isLock(h.transactionCode) ? h.lockSubcode : `APBF_LOCK_ZERO; // R9
        if (h.kind == APBF_KIND_STREAM) begin
            hdrQuad = {h.payloadLength, h.transactionTag[1:0], h.channel,
                       `APBF_TC_STREAM, h.app}; // R14
        end else begin
            case (idx)
                2'h0:    hdrQuad = {h.targetNodeIdentifier[15:6], h.targetNodeIdentifier[5:0],
                                    h.transactionTag, h.retryCode, h.transactionCode,
                                    `APBF_PRIO_ZERO}; // R4 R5 R18 R19
                2'h1:    hdrQuad = {h.senderNodeIdentifier, h.targetOffsetAddress[47:32]}; // R6 R12
                2'h2:    hdrQuad = h.targetOffsetAddress[31:0]; // R12
                default: hdrQuad = (h.kind == APBF_KIND_QUAD) ? h.quadletData
                                                              : {h.payloadLength, sub};
            endcase
        end
    endfunction : hdrQuad

    // handshakes and free space in the receive buffer
    assign room        = `APBF_DEPTH - count_q;
    assign rxHdrReady  = (rxState_q == APBF_RX_IDLE) && (room >= `APBF_ROOM_HDR);
    assign rxDataReady = (rxState_q == APBF_RX_DATA) && (room >= `APBF_ROOM_DATA);
    assign rxEndReady  = (rxState_q == APBF_RX_DATA) && !rxDataValid;
    assign hdrTake     = rxHdrValid && rxHdrReady;
    assign dataTake    = rxDataValid && rxDataReady;
    assign endTake     = rxEndValid && rxEndReady;
    assign headQuad    = recMem[rdPtr_q];

    // receive sequencing: header quadlets, payload, trailer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxState_q <= APBF_RX_IDLE;
            hdrIdx_q  <= 2'h0;
        end else if (ce) begin
            case (rxState_q)
                APBF_RX_IDLE: begin
                    hdrIdx_q <= 2'h0;
                    if (hdrTake) begin
                        rxState_q <= APBF_RX_HDR;
                    end
                end
                APBF_RX_HDR: begin
                    hdrIdx_q <= hdrIdx_q + 2'h1;
                    if (hdr_q.kind == APBF_KIND_STREAM || hdrIdx_q == `APBF_HDR_FULL) begin
                        rxState_q <= APBF_RX_DATA;
                    end
                end
                APBF_RX_DATA: begin
                    if (endTake) begin
                        rxState_q <= APBF_RX_IDLE;
                    end
                end
                default: rxState_q <= APBF_RX_IDLE;
            endcase
        end
    end

    // header latched when taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_q <= '0;
        end else if (ce && hdrTake) begin
            hdr_q <= rxHdr;
        end
    end

    // what goes into the buffer this cycle
    always_comb begin
        memWe    = 1'b0;
        memWdata = 32'h0000_0000;
        case (rxState_q)
            APBF_RX_HDR: begin
                memWe    = 1'b1;
                memWdata = hdrQuad(hdr_q, hdrIdx_q);
            end
            APBF_RX_DATA: begin
                if (dataTake) begin
                    memWe    = 1'b1;
                    memWdata = rxData;
                end else if (endTake) begin
                    memWe    = 1'b1;
                    memWdata = 32'h0000_0000;
                    memWdata[`APBF_TRL_SPD_LSB +: 3] = rxTrailer.speedCode; // R11
                    memWdata[`APBF_TRL_ACK_LSB +: 4] = rxTrailer.returnedAckCode; // R11
                end
            end
            default: memWe = 1'b0;
        endcase
    end

    // record storage
    always_ff @(posedge clk) begin
        if (ce && memWe) begin
            recMem[wrPtr_q] <= memWdata;
        end
    end

    // write pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= 6'h00;
        end else if (ce && memWe) begin
            wrPtr_q <= wrPtr_q + 6'h01;
        end
    end

    // host read of the receive data register: upper half pops, lower half from hold
    assign pop = regRead && (regAddr == `APBF_REG_RX_DATA) && !rxPhase_q && (count_q != 7'h00);

    // read pointer and occupancy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPtr_q <= 6'h00;
            count_q <= 7'h00;
        end else if (ce) begin
            if (pop) begin
                rdPtr_q <= rdPtr_q + 6'h01;
            end
            count_q <= count_q + {6'h00, memWe} - {6'h00, pop};
        end
    end

    // half phase of the receive data register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxPhase_q <= 1'b0;
            lowHold_q <= 16'h0000;
        end else if (ce && regRead && (regAddr == `APBF_REG_RX_DATA)) begin
            if (pop) begin
                rxPhase_q <= 1'b1; // R16
                lowHold_q <= headQuad[15:0];
            end else begin
                rxPhase_q <= 1'b0;
            end
        end
    end

    // node identification register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nodeId_q <= `APBF_NODE_ID_RST;
        end else if (ce && regWrite && (regAddr == `APBF_REG_NODE_ID)) begin
            nodeId_q <= regWdata;
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= `APBF_ZERO16;
        end else if (ce) begin
            regRdata <= `APBF_ZERO16;
            if (regRead) begin
                case (regAddr)
                    `APBF_REG_NODE_ID: regRdata <= nodeId_q;
                    `APBF_REG_RX_DATA: regRdata <= rxPhase_q ? lowHold_q
                                               : (pop ? headQuad[31:16] : `APBF_ZERO16); // R16
                    `APBF_REG_STATUS:  regRdata <= {5'h00, rxState_q != APBF_RX_IDLE,
                                                    rxPhase_q, txUpperPending, 1'b0, count_q};
                    default:           regRdata <= `APBF_ZERO16;
                endcase
            end
        end
    end

    // transmit halves joined into quadlets
    assign txHalf  = regWrite && (regAddr == `APBF_REG_TX_DATA);
    assign txClear = regWrite && (regAddr == `APBF_REG_TX_CTRL) && regWdata[`APBF_CTRL_NEWPKT];

    apbf_word_joiner u_joiner (
        .clk          (clk),
        .rst          (rst),
        .ce           (ce),
        .clear        (txClear),
        .halfValid    (txHalf),
        .half         (regWdata),
        .quadValid    (joinValid),
        .quad         (joinQuad),
        .upperPending (txUpperPending)
    );

    // quadlets to the link with index and the sender identifier of the packet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txValid   <= 1'b0;
            txClear_q <= 1'b0;
            txOut     <= '0;
        end else if (ce) begin
            txValid   <= joinValid;
            txClear_q <= txClear; // delayed so it never meets the quadlet of the pair just before it
            if (txClear_q) begin
                txOut.index <= 8'hFF;
            end else if (joinValid) begin
                txOut.quad  <= joinQuad;
                txOut.index <= txOut.index + 8'h01;
                if (txOut.index == 8'hFF) begin
                    txOut.senderNodeIdentifier <= joinQuad[`APBF_BUSSEL_BIT]
                        ? {`APBF_LOCAL_BUS, nodeId_q[5:0]} : nodeId_q; // R1 R5
                end
            end
        end
    end
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence s_hdr_take;
        hdrTake && rxHdr.kind != APBF_KIND_STREAM;
    endsequence
    sequence s_upper_read;
        regRead && regAddr == `APBF_REG_RX_DATA && !rxPhase_q && count_q != 7'h00;
    endsequence

    a_bus_select_local: assert property ( // R1
        joinValid && txOut.index == 8'hFF && joinQuad[`APBF_BUSSEL_BIT]
        |=> txOut.senderNodeIdentifier[15:6] == `APBF_LOCAL_BUS)
        else $error("local bus not inserted");
    a_bus_select_reg: assert property ( // R1
        joinValid && txOut.index == 8'hFF && !joinQuad[`APBF_BUSSEL_BIT]
        |=> txOut.senderNodeIdentifier == $past(nodeId_q))
        else $error("node bus not used");
    a_hdr_burst: assert property ( // R18
        s_hdr_take |=> (memWe && rxState_q == APBF_RX_HDR)[*4] ##1 rxState_q == APBF_RX_DATA)
        else $error("header burst wrong");
    a_rx_first_quad: assert property ( // R4
        rxState_q == APBF_RX_HDR && hdrIdx_q == 2'h0 && hdr_q.kind != APBF_KIND_STREAM
        |-> memWdata[3:0] == `APBF_PRIO_ZERO && memWdata[31:16] == hdr_q.targetNodeIdentifier
            && memWdata[7:4] == hdr_q.transactionCode && memWdata[9:8] == hdr_q.retryCode)
        else $error("first record quadlet wrong");
    a_rx_sender_off: assert property ( // R6
        rxState_q == APBF_RX_HDR && hdrIdx_q == 2'h1 && hdr_q.kind != APBF_KIND_STREAM
        |-> memWdata == {hdr_q.senderNodeIdentifier, hdr_q.targetOffsetAddress[47:32]}
        ##1 memWdata == hdr_q.targetOffsetAddress[31:0])
        else $error("sender or offset wrong"); // R12
    a_rx_lock_zero: assert property ( // R9
        rxState_q == APBF_RX_HDR && hdrIdx_q == 2'h3 && hdr_q.kind == APBF_KIND_BLOCK
        && !isLock(hdr_q.transactionCode) |-> memWdata[15:0] == `APBF_LOCK_ZERO)
        else $error("lock subcode not cleared");
    a_rx_stream_code: assert property ( // R14
        rxState_q == APBF_RX_HDR && hdr_q.kind == APBF_KIND_STREAM
        |-> memWdata[7:4] == `APBF_TC_STREAM && memWdata[31:16] == hdr_q.payloadLength
        ##1 rxState_q == APBF_RX_DATA)
        else $error("stream record wrong");
    a_rx_trailer: assert property ( // R11
        endTake |-> memWe && memWdata[`APBF_TRL_SPD_LSB +: 3] == rxTrailer.speedCode
        && memWdata[`APBF_TRL_ACK_LSB +: 4] == rxTrailer.returnedAckCode
        ##1 rxState_q == APBF_RX_IDLE)
        else $error("trailer wrong");
    a_half_order: assert property ( // R16
        s_upper_read |=> regRdata == $past(headQuad[31:16]) && rxPhase_q)
        else $error("upper half wrong");

endmodule : apbf_async_packet_buffer_format

// *** apbf_link_model.sv ***
// Purpose: link-side model offering received packets and collecting transmit quadlets
// Assumes: readies sampled at rising edges of clk
// Notes:   released buses carry the inverse of their last value
`timescale 1ns/1ps
module apbf_link_model
    import apbf_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    output apbf_rx_hdr_t       rxHdr,
    output logic               rxHdrValid,
    input  wire logic          rxHdrReady,
    output logic               rxDataValid,
    output logic [31:0]        rxData,
    input  wire logic          rxDataReady,
    output logic               rxEndValid,
    output apbf_rx_trl_t       rxTrailer,
    input  wire logic          rxEndReady,
    input  wire logic          txValid,
    input  wire apbf_tx_quad_t txOut
);
    apbf_tx_quad_t txQ [$];

    // idle levels from time zero
    initial begin
        rxHdrValid  = 1'b0;
        rxDataValid = 1'b0;
        rxEndValid  = 1'b0;
        rxHdr       = '0;
        rxData      = 32'h0;
        rxTrailer   = '0;
    end

    // collect every quadlet handed to the link
    always @(posedge clk) begin
        if (!rst && txValid) begin
            txQ.push_back(txOut);
        end
    end

    // header, payload with optional stall between quadlets, then trailer
    task automatic send(input apbf_rx_hdr_t h, input logic [31:0] pl [$], input apbf_rx_trl_t t, input int stall);
        @(posedge clk);
        rxHdrValid <= 1'b1;
        rxHdr      <= h;
        @(posedge clk);
        while (!rxHdrReady) @(posedge clk);
        rxHdrValid <= 1'b0;
        rxHdr      <= ~h;
        foreach (pl[i]) begin
            if (i > 0 && stall > 0) begin
                rxDataValid <= 1'b0;
                rxData      <= ~pl[i-1];
                repeat (stall) @(posedge clk);
            end
            rxDataValid <= 1'b1;
            rxData      <= pl[i];
            @(posedge clk);
            while (!rxDataReady) @(posedge clk);
        end
        if (pl.size() > 0) begin
            rxDataValid <= 1'b0;
            rxData      <= ~pl[pl.size()-1];
        end
        rxEndValid <= 1'b1;
        rxTrailer  <= t;
        @(posedge clk);
        while (!rxEndReady) @(posedge clk);
        rxEndValid <= 1'b0;
        rxTrailer  <= ~t;
    endtask : send
endmodule : apbf_link_model

// *** apbf_async_packet_buffer_format_test.sv ***
// Purpose: self-checking bench for the async packet buffer formatter
// Assumes: register port strobes one cycle, read data one cycle later
// Notes:   expected records built here from the field layout
`timescale 1ns/1ps
`include "apbf_map.svh"
module apbf_async_packet_buffer_format_test
    import apbf_pkg::*;
;
    localparam apbf_kind_t KINDS [5] = '{APBF_KIND_QUAD, APBF_KIND_BLOCK, APBF_KIND_BLOCK, APBF_KIND_BLOCK,
                                         APBF_KIND_STREAM};
    localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h9, 4'hB, 4'hA};
    localparam int         NPL   [5] = '{0, 3, 1, 1, 2};

    logic          clk = 1'b0;
    logic          rst;
    logic [2:0]    regAddr;
    logic [15:0]   regWdata;
    logic          regWrite;
    logic          regRead;
    logic [15:0]   regRdata;
    apbf_rx_hdr_t  rxHdr;
    logic          rxHdrValid, rxHdrReady, rxDataValid, rxDataReady, rxEndValid, rxEndReady, txValid;
    logic [31:0]   rxData;
    apbf_rx_trl_t  rxTrailer;
    apbf_tx_quad_t txOut;
    int            error_cnt = 0;
    int            num_checks = 0;
    int            cycles = 0;
    logic [31:0]   expQ [$];

    // clock
    always #10 clk = ~clk;

    apbf_async_packet_buffer_format dut (
        .clk(clk), .rst(rst), .ce(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .rxHdrValid(rxHdrValid), .rxHdr(rxHdr),
        .rxHdrReady(rxHdrReady), .rxDataValid(rxDataValid), .rxData(rxData), .rxDataReady(rxDataReady),
        .rxEndValid(rxEndValid), .rxTrailer(rxTrailer), .rxEndReady(rxEndReady), .txValid(txValid),
        .txOut(txOut));

    apbf_link_model link (
        .clk(clk), .rst(rst), .rxHdr(rxHdr), .rxHdrValid(rxHdrValid), .rxHdrReady(rxHdrReady),
        .rxDataValid(rxDataValid), .rxData(rxData), .rxDataReady(rxDataReady), .rxEndValid(rxEndValid),
        .rxTrailer(rxTrailer), .rxEndReady(rxEndReady), .txValid(txValid), .txOut(txOut));

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read

    // one transmit packet, each quadlet as two halves, then compare what reached the link
    task automatic tx_packet(input logic [31:0] pk [$], input logic [15:0] snd);
        logic [15:0] s;
        link.txQ.delete();
        reg_write(`APBF_REG_TX_CTRL, 16'h0001);
        foreach (pk[i]) begin
            reg_write(`APBF_REG_TX_DATA, pk[i][31:16]);
            reg_read(`APBF_REG_STATUS, s);
            check("txUpperPending", {31'h0, s[8]}, 32'h1);
            reg_write(`APBF_REG_TX_DATA, pk[i][15:0]);
        end
        repeat (3) @(posedge clk);
        check("txCount", 32'(link.txQ.size()), 32'(pk.size()));
        foreach (pk[i]) begin
            check("txQuad", link.txQ[i].quad, pk[i]);
            check("txIndex", {24'h0, link.txQ[i].index}, 32'(i));
            check("txSender", {16'h0, link.txQ[i].senderNodeIdentifier}, {16'h0, snd});
        end
    endtask : tx_packet

    // one received packet, then the record read back in halves
    task automatic rx_case(input apbf_rx_hdr_t h, input int n, input int stall, input apbf_rx_trl_t t);
        logic [31:0] pl [$];
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] s;
        expQ.delete();
        for (int i = 0; i < n; i++) begin
            pl.push_back(32'hA5C3_0000 + 32'(i));
        end
        if (h.kind == APBF_KIND_STREAM) begin
            expQ.push_back({h.payloadLength, h.transactionTag[1:0], h.channel, 4'hA, h.app});
        end else begin
            expQ.push_back({h.targetNodeIdentifier, h.transactionTag, h.retryCode, h.transactionCode, 4'h0});
            expQ.push_back({h.senderNodeIdentifier, h.targetOffsetAddress[47:32]});
            expQ.push_back(h.targetOffsetAddress[31:0]);
            if (h.kind == APBF_KIND_QUAD) begin
                expQ.push_back(h.quadletData);
            end else begin
                expQ.push_back({h.payloadLength,
                                (h.transactionCode == 4'h9 || h.transactionCode == 4'hB) ? h.lockSubcode : 16'h0});
            end
        end
        foreach (pl[i]) begin
            expQ.push_back(pl[i]);
        end
        expQ.push_back({13'h0, t.speedCode, 12'h0, t.returnedAckCode});
        link.send(h, pl, t, stall);
        repeat (2) @(posedge clk);
        reg_read(`APBF_REG_STATUS, s);
        check("rxStatus", {16'h0, s}, {25'h0, 7'(expQ.size())});
        foreach (expQ[i]) begin
            reg_read(`APBF_REG_RX_DATA, hi);
            reg_read(`APBF_REG_STATUS, s);
            check("rxLowerPending", {31'h0, s[9]}, 32'h1);
            reg_read(`APBF_REG_RX_DATA, lo);
            check("rxRecord", {hi, lo}, expQ[i]);
        end
        reg_read(`APBF_REG_RX_DATA, s);
        check("rxDrained", {16'h0, s}, 32'h0);
    endtask : rx_case

    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        logic [15:0]  d;
        apbf_rx_hdr_t h;
        apbf_rx_trl_t t;
        rst      = 1'b1;
        regAddr  = 3'h0;
        regWdata = 16'h0;
        regWrite = 1'b0;
        regRead  = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reg_read(`APBF_REG_NODE_ID, d);
        check("nodeIdReset", {16'h0, d}, 32'h0000_FFC0);
        reg_read(`APBF_REG_STATUS, d);
        check("statusReset", {16'h0, d}, 32'h0);
        reg_read(`APBF_REG_RX_DATA, d);
        check("rxEmpty", {16'h0, d}, 32'h0);
        reg_write(3'h5, 16'hFFFF);
        reg_read(3'h5, d);
        check("unmapped", {16'h0, d}, 32'h0);
        reg_write(`APBF_REG_NODE_ID, {10'h123, 6'h15});
        reg_read(`APBF_REG_NODE_ID, d);
        check("nodeId", {16'h0, d}, {16'h0, 10'h123, 6'h15});
        // block response from the node register bus, then local bus, then a stream
        tx_packet('{32'h0000_3D70, 32'h48D5_0000, 32'h0, 32'h0006_0000, 32'h1122_3344, 32'h5566_0000},
                  {10'h123, 6'h15});
        tx_packet('{32'h0080_3D70, 32'h48D5_0000, 32'h0, 32'h0004_0000, 32'h7788_99AA},
                  {10'h3FF, 6'h15});
        tx_packet('{32'h0000_00A0, 32'h0004_6A05, 32'h89AB_CDEF}, {10'h123, 6'h15});
        // quad, block with stalls, both lock codes, stream
        for (int k = 0; k < 5; k++) begin
            h = '{kind: KINDS[k], transactionCode: CODES[k], transactionTag: 6'h0D, retryCode: 2'h2,
                  targetNodeIdentifier: 16'h48D5, senderNodeIdentifier: 16'hFFC2,
                  targetOffsetAddress: 48'hFFFF_F000_0A04, payloadLength: 16'h000C, lockSubcode: 16'h0003,
                  quadletData: 32'hDEAD_1234, channel: 6'h2A, app: 4'h5};
            t = '{speedCode: 3'(k), returnedAckCode: 4'h1 + 4'(k)};
            rx_case(h, NPL[k], (k == 1) ? 2 : 0, t);
        end
        wrap_up();
    end
endmodule : apbf_async_packet_buffer_format_test
